// [design/pdm_pkg.sv]
// constants and types for the power-down mode controller
package pdm_pkg;

    // ****************************************
    // register map (index = printed offset)
    // ****************************************
    localparam logic [15:0] PDM_IDX_STANDBY_CTRL = 16'hFE14;
    localparam logic [15:0] PDM_IDX_STOP_HI = 16'hFE16;
    localparam logic [15:0] PDM_IDX_STOP_LO = 16'hFE17;
    localparam logic [15:0] PDM_IDX_STATUS = 16'hFE18;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int PDM_SW_STANDBY_SELECT_POS = 7;
    localparam int PDM_WAIT_SELECT_HI = 6;
    localparam int PDM_WAIT_SELECT_LO = 4;
    localparam int PDM_TIMER_STOP_POS = 4;
    localparam int PDM_SERIAL_STOP_POS = 7;
    localparam int PDM_USB_STOP_POS = 4;
    localparam logic [7:0] PDM_STANDBY_CTRL_RST = 8'h00;
    localparam logic [7:0] PDM_STOP_HI_RST = 8'h3F;
    localparam logic [7:0] PDM_STOP_LO_RST = 8'hFF;

    // ****************************************
    // wait select codes and short wait
    // ****************************************
    localparam logic [2:0] PDM_WAIT_CODE_RSVD = 3'h6;
    localparam logic [2:0] PDM_WAIT_CODE_SHORT = 3'h7;
    localparam logic [18:0] PDM_WAIT_SHORT = 19'h00010;

    // ****************************************
    // operating modes
    // ****************************************
    typedef enum logic [2:0] {
        PDM_RUN = 3'b000,
        PDM_SLEEP = 3'b001,
        PDM_SW_STANDBY = 3'b010,
        PDM_OSC_WAIT = 3'b011,
        PDM_RESET = 3'b100,
        PDM_HW_STANDBY = 3'b101
    } pdm_mode_e;

endpackage

// [design/pdm_top.sv]
// power-down mode controller: sleep, standby, module stop
`timescale 1ns/1ps
`default_nettype none

module pdm_top import pdm_pkg::*; #(
    parameter logic [18:0] WAIT_BASE = 19'h02000 // wait of code 0
) (
    input wire logic clk_i, // 10 MHz clock
    input wire logic rst_i, // synchronous reset
    input wire logic ce_i, // clock enable
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [17:0] adr_i, // byte address
    input wire logic [3:0] sel_i, // byte lanes
    input wire logic [31:0] dat_i, // write data
    output logic [31:0] dat_o, // read data
    output logic ack_o, // acknowledge
    input wire logic sleep_exec_i, // cpu runs sleep instruction
    input wire logic int_req_i, // enabled interrupt pending
    input wire logic cpu_mask_i, // cpu masks non-nmi
    input wire logic nmi_i, // nmi pin event
    input wire logic [7:0] irq_pin_i, // external irq pins
    input wire logic [7:0] irq_en_i, // irq enable bits
    input wire logic usb_suspend_resume_irq_i, // usb wake request
    input wire logic reset_input_pin_n_i, // reset pin
    input wire logic hw_standby_pin_n_i, // standby pin
    output logic cpu_halt_o, // cpu stopped
    output logic cpu_reset_o, // chip held in reset
    output logic periph_run_o, // peripheral clocks on
    output logic osc_en_o, // oscillator running
    output logic chip_clk_en_o, // clocks supplied to chip
    output logic io_hiz_o, // ports high impedance
    output logic serial_reset_o, // serial unit reset
    output logic timer_stop_o, // timer stopped
    output logic serial_stop_o, // serial unit stopped
    output logic usb_stop_o, // usb unit stopped
    output logic int_exception_o, // start interrupt handling
    output logic reset_exception_o, // start reset handling
    output logic [2:0] mode_o // current mode
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] hws_sync;
        logic [1:0] nmi_sync;
        logic [7:0] irq_s1;
        logic [7:0] irq_s2;
        pdm_mode_e mode;
        logic [18:0] cnt;
        logic [18:0] target;
        logic [7:0] standby_ctrl_reg;
        logic [7:0] stop_hi;
        logic [7:0] stop_lo;
        logic ack;
        logic [31:0] rdata;
        logic cpu_halt;
        logic cpu_reset;
        logic periph_run;
        logic osc_en;
        logic chip_clk;
        logic io_hiz;
        logic serial_reset;
        logic int_exc;
        logic rst_exc;
    } pdm_state_s;

    pdm_state_s q;
    pdm_state_s next_q;

    // ****************************************
    // wait select decode
    // ****************************************
    // each long code doubles the wait of the one below it
    // reserved code falls back to the longest wait
    function automatic logic [18:0] wait_len(input logic [2:0] code);
        case (code)
            3'h0: wait_len = WAIT_BASE;
            3'h1: wait_len = WAIT_BASE << 3'h1;
            3'h2: wait_len = WAIT_BASE << 3'h2;
            3'h3: wait_len = WAIT_BASE << 3'h3;
            3'h4: wait_len = WAIT_BASE << 3'h4;
            3'h5: wait_len = WAIT_BASE << 3'h5;
            PDM_WAIT_CODE_RSVD: wait_len = WAIT_BASE << 3'h5;
            PDM_WAIT_CODE_SHORT: wait_len = PDM_WAIT_SHORT;
            default: wait_len = WAIT_BASE << 3'h5;
        endcase
    endfunction

    logic rst_pin;
    logic hws_pin;
    logic nmi_ev;
    logic sleep_wake;
    logic hw_standby_pin_n_wake;
    logic bus_req;
    logic [15:0] idx;
    logic in_reset;

    always_comb begin
        rst_pin = q.rst_sync[1];
        hws_pin = q.hws_sync[1];
        nmi_ev = q.nmi_sync[1];
        sleep_wake = nmi_ev | (int_req_i & ~cpu_mask_i);
        hw_standby_pin_n_wake = nmi_ev | (~cpu_mask_i & ((|(q.irq_s2 & irq_en_i))
            | usb_suspend_resume_irq_i));
        bus_req = cyc_i & stb_i & ~q.ack;
        idx = adr_i[17:2];
        in_reset = (q.mode == PDM_RESET) | (q.mode == PDM_HW_STANDBY);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_q = q;
        next_q.rst_sync = {q.rst_sync[0], reset_input_pin_n_i};
        next_q.hws_sync = {q.hws_sync[0], hw_standby_pin_n_i};
        next_q.nmi_sync = {q.nmi_sync[0], nmi_i};
        next_q.irq_s1 = irq_pin_i;
        next_q.irq_s2 = q.irq_s1;
        next_q.int_exc = 1'b0;
        next_q.rst_exc = 1'b0;
        next_q.ack = bus_req;

        // mode sequencing
        if (!hws_pin) begin
            next_q.mode = PDM_HW_STANDBY;
        end else if (!rst_pin) begin
            next_q.mode = PDM_RESET;
        end else begin
            case (q.mode)
                PDM_RUN: begin
                    if (sleep_exec_i) begin
                        if (q.standby_ctrl_reg[PDM_SW_STANDBY_SELECT_POS]) begin
                            next_q.mode = PDM_SW_STANDBY;
                        end else begin
                            next_q.mode = PDM_SLEEP;
                        end
                    end
                end
                PDM_SLEEP: begin
                    if (sleep_wake) begin
                        next_q.mode = PDM_RUN;
                        next_q.int_exc = 1'b1;
                    end
                end
                PDM_SW_STANDBY: begin
                    if (hw_standby_pin_n_wake) begin
                        next_q.mode = PDM_OSC_WAIT;
                        next_q.cnt = 19'h00000;
                        next_q.target = wait_len(
                            q.standby_ctrl_reg[PDM_WAIT_SELECT_HI:
                                PDM_WAIT_SELECT_LO]);
                    end
                end
                PDM_OSC_WAIT: begin
                    if (q.cnt == q.target - 19'h00001) begin
                        next_q.mode = PDM_RUN;
                        next_q.int_exc = 1'b1;
                    end else begin
                        next_q.cnt = q.cnt + 19'h00001;
                    end
                end
                PDM_RESET, PDM_HW_STANDBY: begin
                    next_q.mode = PDM_RUN;
                    next_q.rst_exc = (q.mode == PDM_RESET);
                end
                default: next_q.mode = PDM_RUN;
            endcase
        end

        // register access, write takes effect with the answer
        next_q.rdata = 32'h00000000;
        if (bus_req) begin
            case (idx)
                PDM_IDX_STANDBY_CTRL: begin
                    next_q.rdata = {24'h000000, q.standby_ctrl_reg};
                    if (we_i && sel_i[0]) begin
                        next_q.standby_ctrl_reg = dat_i[7:0];
                    end
                end
                PDM_IDX_STOP_HI: begin
                    next_q.rdata = {24'h000000, q.stop_hi};
                    if (we_i && sel_i[0]) begin
                        next_q.stop_hi = dat_i[7:0];
                    end
                end
                PDM_IDX_STOP_LO: begin
                    next_q.rdata = {24'h000000, q.stop_lo};
                    if (we_i && sel_i[0]) begin
                        next_q.stop_lo = dat_i[7:0];
                    end
                end
                PDM_IDX_STATUS: next_q.rdata = {29'h00000000, q.mode};
                default: next_q.rdata = 32'h00000000;
            endcase
        end

        // reset and hardware standby reinitialise the controls
        if (in_reset) begin
            next_q.standby_ctrl_reg = PDM_STANDBY_CTRL_RST;
            next_q.stop_hi = PDM_STOP_HI_RST;
            next_q.stop_lo = PDM_STOP_LO_RST;
        end

        // registered outputs from the next mode, serial reset also from the next serial stop bit
        next_q.cpu_halt = (next_q.mode == PDM_SLEEP)
            | (next_q.mode == PDM_SW_STANDBY)
            | (next_q.mode == PDM_OSC_WAIT);
        next_q.cpu_reset = (next_q.mode == PDM_RESET)
            | (next_q.mode == PDM_HW_STANDBY);
        next_q.periph_run = (next_q.mode == PDM_RUN)
            | (next_q.mode == PDM_SLEEP);
        next_q.osc_en = (next_q.mode != PDM_SW_STANDBY)
            & (next_q.mode != PDM_HW_STANDBY);
        next_q.chip_clk = (next_q.mode == PDM_RUN)
            | (next_q.mode == PDM_SLEEP)
            | (next_q.mode == PDM_RESET);
        next_q.io_hiz = (next_q.mode == PDM_HW_STANDBY);
        next_q.serial_reset = next_q.cpu_reset
            | (next_q.mode == PDM_SW_STANDBY)
            | next_q.stop_lo[PDM_SERIAL_STOP_POS];
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.rst_sync <= 2'h3;
            q.hws_sync <= 2'h3;
            q.mode <= PDM_RESET;
            q.standby_ctrl_reg <= PDM_STANDBY_CTRL_RST;
            q.stop_hi <= PDM_STOP_HI_RST;
            q.stop_lo <= PDM_STOP_LO_RST;
            q.cpu_reset <= 1'b1;
            q.osc_en <= 1'b1;
            q.chip_clk <= 1'b1;
            q.serial_reset <= 1'b1;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        dat_o = q.rdata;
        ack_o = q.ack;
        cpu_halt_o = q.cpu_halt;
        cpu_reset_o = q.cpu_reset;
        periph_run_o = q.periph_run;
        osc_en_o = q.osc_en;
        chip_clk_en_o = q.chip_clk;
        io_hiz_o = q.io_hiz;
        serial_reset_o = q.serial_reset;
        // stop outputs come straight from the stop register bits
        timer_stop_o = q.stop_hi[PDM_TIMER_STOP_POS];
        serial_stop_o = q.stop_lo[PDM_SERIAL_STOP_POS];
        usb_stop_o = q.stop_lo[PDM_USB_STOP_POS];
        int_exception_o = q.int_exc;
        reset_exception_o = q.rst_exc;
        mode_o = q.mode;
    end

endmodule

`default_nettype wire

// [dv/pdm_monitor.sv]
// assertion checker on the power-down controller ports
`timescale 1ns/1ps
`default_nettype none
module pdm_monitor import pdm_pkg::*; (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic cyc_i, // bus cycle
    input wire logic stb_i, // bus strobe
    input wire logic sleep_exec_i, // sleep request
    input wire logic int_req_i, // interrupt
    input wire logic cpu_mask_i, // cpu mask
    input wire logic nmi_i, // nmi
    input wire logic [7:0] irq_pin_i, // irq pins
    input wire logic usb_suspend_resume_irq_i, // usb wake
    input wire logic reset_input_pin_n_i, // reset pin
    input wire logic hw_standby_pin_n_i, // standby pin
    input wire logic ack_o, // ack
    input wire logic cpu_reset_o, // chip reset
    input wire logic osc_en_o, // oscillator
    input wire logic chip_clk_en_o, // chip clocks
    input wire logic io_hiz_o, // ports float
    input wire logic serial_reset_o, // serial reset
    input wire logic serial_stop_o, // serial stop
    input wire logic int_exception_o, // int start
    input wire logic reset_exception_o, // reset start
    input wire logic [2:0] mode_o // mode
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence pins_hi;
        (reset_input_pin_n_i && hw_standby_pin_n_i)[*3];
    endsequence
    sequence no_wake;
        (reset_input_pin_n_i && hw_standby_pin_n_i && !nmi_i
            && irq_pin_i == 8'h00 && !usb_suspend_resume_irq_i)[*3];
    endsequence
    a_sleep_enter: assert property (
        pins_hi ##0 (mode_o == PDM_RUN && sleep_exec_i)
        |=> mode_o inside {PDM_SLEEP, PDM_SW_STANDBY})
        else $error("sleep not entered");
    a_sleep_wake: assert property (
        pins_hi ##0 (mode_o == PDM_SLEEP && int_req_i && !cpu_mask_i)
        |=> mode_o == PDM_RUN && int_exception_o)
        else $error("sleep wake wrong");
    a_sleep_masked: assert property (
        no_wake ##0 (mode_o == PDM_SLEEP && cpu_mask_i)
        |=> mode_o == PDM_SLEEP) else $error("masked woke");
    a_standby_hold: assert property (
        no_wake ##0 mode_o == PDM_SW_STANDBY |=> mode_o == PDM_SW_STANDBY)
        else $error("standby left");
    a_standby_outs: assert property (
        mode_o == PDM_SW_STANDBY |-> !osc_en_o && !chip_clk_en_o
        && serial_reset_o) else $error("standby outputs");
    a_osc_wait: assert property (
        mode_o == PDM_OSC_WAIT |-> osc_en_o && !chip_clk_en_o)
        else $error("wait outputs");
    a_hw_enter: assert property (
        (!hw_standby_pin_n_i)[*3] |=> mode_o == PDM_HW_STANDBY && io_hiz_o
        && cpu_reset_o && !osc_en_o) else $error("no hardware standby");
    a_pin_reset: assert property (
        (!reset_input_pin_n_i && hw_standby_pin_n_i)[*3] |=>
        mode_o == PDM_RESET && osc_en_o && chip_clk_en_o)
        else $error("no reset state");
    a_reset_exc: assert property (
        reset_exception_o |-> mode_o == PDM_RUN
        && $past(mode_o) == PDM_RESET ##1 !reset_exception_o)
        else $error("reset start wrong");
    a_serial_rst: assert property (
        serial_stop_o |-> serial_reset_o) else $error("serial not reset");
    a_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o
        ##1 !ack_o) else $error("ack timing");
endmodule
`default_nettype wire

// [dv/pdm_ext_sys.sv]
// model of the board logic driving the reset and standby pins
`timescale 1ns/1ps
`default_nettype none
module pdm_ext_sys #(
    parameter int SETTLE = 8
) (
    input wire logic clk_i, // clock
    input wire logic want_reset_i, // reset asked
    input wire logic want_standby_i, // standby asked
    input wire logic osc_en_i, // oscillator running
    output logic reset_pin_n_o = 1'h1, // reset pin
    output logic standby_pin_n_o = 1'h1 // standby pin
);
    // ****
    // pin drive
    // ****
    int settle = 0;
    logic hold = 1'h0;
    always @(posedge clk_i) begin
        standby_pin_n_o <= !want_standby_i;
        // reset stays low until the oscillator has run SETTLE cycles
        settle <= (want_reset_i || !osc_en_i) ? 0 : settle + (settle < SETTLE);
        hold <= want_reset_i || (hold && settle < SETTLE);
        reset_pin_n_o <= !(want_reset_i || hold);
    end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the power-down mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench import pdm_pkg::*;;
    // ****
    // signals, design, pin model
    // ****
    logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic ce_i = 1'h1;
    logic [3:0] sel_i = 4'h1, wsel = 4'h1;
    logic sleep_exec_i = 1'h0, int_req_i = 1'h0, cpu_mask_i = 1'h0;
    logic nmi_i = 1'h0, usb_suspend_resume_irq_i = 1'h0;
    logic want_reset = 1'h0, want_standby = 1'h0, ie = 1'h0, re = 1'h0;
    logic [17:0] adr_i = 18'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [7:0] irq_pin_i = 8'h00, irq_en_i = 8'h00;
    logic ack_o, cpu_halt_o, cpu_reset_o, periph_run_o, osc_en_o;
    logic chip_clk_en_o, io_hiz_o, serial_reset_o, timer_stop_o;
    logic serial_stop_o, usb_stop_o, int_exception_o, reset_exception_o;
    logic reset_input_pin_n_i, hw_standby_pin_n_i;
    logic [2:0] mode_o;
    int err_count = 0, samples_checked = 0, n, k;
    // base 4 stands for 8192 states; short code only on non-flash parts;
    // the model oscillator settles at once, so every code covers it
    int wt[8] = '{4, 8, 16, 32, 64, 128, 128, PDM_WAIT_SHORT};
    pdm_top #(.WAIT_BASE(19'h00004)) dut (
        .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .sleep_exec_i, .int_req_i,
        .cpu_mask_i, .nmi_i, .irq_pin_i, .irq_en_i, .usb_suspend_resume_irq_i,
        .reset_input_pin_n_i, .hw_standby_pin_n_i, .cpu_halt_o, .cpu_reset_o,
        .periph_run_o, .osc_en_o, .chip_clk_en_o, .io_hiz_o, .serial_reset_o,
        .timer_stop_o, .serial_stop_o, .usb_stop_o, .int_exception_o,
        .reset_exception_o, .mode_o);
    pdm_ext_sys ext (.clk_i, .want_reset_i(want_reset),
        .want_standby_i(want_standby), .osc_en_i(osc_en_o),
        .reset_pin_n_o(reset_input_pin_n_i),
        .standby_pin_n_o(hw_standby_pin_n_i));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (int_exception_o) ie <= 1'h1;
        if (reset_exception_o) re <= 1'h1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wm(input logic [2:0] m);
        int i;
        for (i = 0; i < 3000 && mode_o !== m; i++) @(posedge clk_i);
        chk(32'(mode_o), 32'(m));
        if (i == 3000) report_and_stop();
    endtask
    task automatic wb(input logic w, input logic [15:0] ix, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        sel_i <= wsel;
        adr_i <= {ix, 2'h0};
        dat_i <= {24'h0, d};
        for (i = 0; i < 50 && ack_o !== 1'h1; i++) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        if (i == 50) err_count++;
        if (i == 50) report_and_stop();
    endtask
    task automatic sleep_now(input logic [7:0] ctrl, input logic [2:0] m);
        wb(1'h1, PDM_IDX_STANDBY_CTRL, ctrl);
        @(posedge clk_i);
        sleep_exec_i <= 1'h1;
        @(posedge clk_i);
        sleep_exec_i <= 1'h0;
        wm(m);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        wm(PDM_RUN);
        @(posedge clk_i);
        chk(32'(re), 32'h1);
        wb(1'h0, PDM_IDX_STANDBY_CTRL, 8'h00);
        chk(q, 32'(PDM_STANDBY_CTRL_RST));
        wb(1'h0, PDM_IDX_STOP_HI, 8'h00);
        chk(q, 32'(PDM_STOP_HI_RST));
        wb(1'h0, PDM_IDX_STOP_LO, 8'h00);
        chk(q, 32'(PDM_STOP_LO_RST));
        wb(1'h0, 16'hFE1C, 8'h00);
        chk(q, 32'h0);
        // lane 0 off: the write is dropped
        wsel = 4'hE;
        wb(1'h1, PDM_IDX_STOP_HI, 8'h00);
        wsel = 4'h1;
        wb(1'h0, PDM_IDX_STOP_HI, 8'h00);
        chk(q, 32'(PDM_STOP_HI_RST));
        // only the cpu writes stop bits, wake sources all disabled
        wb(1'h1, PDM_IDX_STOP_HI, 8'h2F);
        wb(1'h1, PDM_IDX_STOP_LO, 8'hEF);
        repeat (2) @(posedge clk_i);
        chk(32'({timer_stop_o, serial_stop_o, serial_reset_o, usb_stop_o}),
            32'h6);
        wb(1'h1, PDM_IDX_STOP_LO, 8'h6F);
        sleep_now(8'h00, PDM_SLEEP);
        chk(32'({cpu_halt_o, periph_run_o, serial_reset_o}), 32'h6);
        cpu_mask_i <= 1'h1;
        int_req_i <= 1'h1;
        repeat (8) @(posedge clk_i);
        chk(32'(mode_o), 32'(PDM_SLEEP));
        wb(1'h0, PDM_IDX_STATUS, 8'h00);
        chk(q, 32'(PDM_SLEEP));
        ie = 1'h0;
        cpu_mask_i <= 1'h0;
        wm(PDM_RUN);
        int_req_i <= 1'h0;
        @(posedge clk_i);
        chk(32'(ie), 32'h1);
        for (k = 0; k < 8; k++) begin
            irq_en_i <= 8'h01 << k;
            sleep_now({1'h1, 3'(k), 4'h0}, PDM_SW_STANDBY);
            int_req_i <= 1'h1;
            repeat (8) @(posedge clk_i);
            chk(32'(mode_o), 32'(PDM_SW_STANDBY));
            int_req_i <= 1'h0;
            ie = 1'h0;
            irq_pin_i <= (k < 6) ? 8'h01 << k : 8'h00;
            usb_suspend_resume_irq_i <= (k == 6);
            nmi_i <= (k == 7);
            wm(PDM_OSC_WAIT);
            irq_pin_i <= 8'h00;
            usb_suspend_resume_irq_i <= 1'h0;
            nmi_i <= 1'h0;
            // on the short code the clock enable freezes the count 5 edges
            for (n = 0; n < 300 && mode_o === PDM_OSC_WAIT; n++) begin
                ce_i <= !(k == 7 && n < 5);
                @(posedge clk_i);
            end
            chk(n, wt[k] + ((k == 7) ? 5 : 0));
            @(posedge clk_i);
            chk(32'({ie, mode_o}), 32'({1'h1, PDM_RUN}));
            wb(1'h0, PDM_IDX_STANDBY_CTRL, 8'h00);
            chk(q, 32'({1'h1, 3'(k), 4'h0}));
        end
        for (k = 0; k < 3; k++) begin
            sleep_now(k ? 8'h80 : 8'h00, k ? PDM_SW_STANDBY : PDM_SLEEP);
            // no ram enable or mode pins in this model
            want_standby <= (k == 2);
            if (k == 2) wm(PDM_HW_STANDBY);
            chk(32'({io_hiz_o, cpu_reset_o}),
                k == 2 ? 32'h3 : 32'h0);
            want_reset <= 1'h1;
            repeat (4) @(posedge clk_i);
            want_standby <= 1'h0;
            wm(PDM_RESET);
            chk(32'({osc_en_o, chip_clk_en_o}), 32'h3);
            re = 1'h0;
            want_reset <= 1'h0;
            wm(PDM_RUN);
            @(posedge clk_i);
            chk(32'(re), 32'h1);
            wb(1'h0, PDM_IDX_STOP_LO, 8'h00);
            chk(q, 32'(PDM_STOP_LO_RST));
            wb(1'h1, PDM_IDX_STOP_LO, 8'h6F);
        end
        report_and_stop();
    end
endmodule
bind pdm_top pdm_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .sleep_exec_i,
    .int_req_i, .cpu_mask_i, .nmi_i, .irq_pin_i, .usb_suspend_resume_irq_i,
    .reset_input_pin_n_i, .hw_standby_pin_n_i, .ack_o, .cpu_reset_o,
    .osc_en_o, .chip_clk_en_o, .io_hiz_o, .serial_reset_o, .serial_stop_o,
    .int_exception_o, .reset_exception_o, .mode_o);
`default_nettype wire
